// >>> hdl/tfp_timer16.sv
// 16-bit timer: clear-on-match and fast pwm counting, flags, waveforms
// assumes synchronous inputs, one clock, an Avalon-MM master on the bus
`timescale 1ns/1ps
module tfp_timer16
    import tfp_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic [4:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    input wire logic [NUM_CH-1:0] wave_pin_i,
    output logic [NUM_CH-1:0] wave_pin_o,
    output logic [NUM_CH-1:0] wave_pin_oe_o
);

    // fast pwm single-slope modes
    function automatic logic is_fpwm(input logic [3:0] m);
        return m inside {MODE_FP8, MODE_FP9, MODE_FP10,
                         MODE_FP_CAP, MODE_FP_A};
    endfunction : is_fpwm

    // clear-on-match modes
    function automatic logic is_ctc(input logic [3:0] m);
        return (m == MODE_CTC_A) || (m == MODE_CTC_CAP);
    endfunction : is_ctc

    // modes whose top is the capture register
    function automatic logic top_is_cap(input logic [3:0] m);
        return (m == MODE_CTC_CAP) || (m == MODE_FP_CAP);
    endfunction : top_is_cap

    // compare write mask for fixed tops
    function automatic logic [15:0] fix_mask(input logic [3:0] m);
        unique case (m)
            MODE_FP8: return TOP_8;
            MODE_FP9: return TOP_9;
            MODE_FP10: return TOP_10;
            default: return CNT_MAX;
        endcase
    endfunction : fix_mask

    logic [15:0] ctrl;
    logic [15:0] count;
    logic [15:0] cap_top;
    logic [15:0] cmp_buf [NUM_CH];
    logic [15:0] cmp_act [NUM_CH];
    logic [3:0] flags;
    logic [NUM_CH-1:0] wave;
    logic [NUM_CH-1:0] next_wave;
    logic [9:0] pre;
    logic tick;
    logic [15:0] top;
    logic match_top;
    logic wr;
    logic [3:0] mode;
    logic [2:0] cs;
    logic fpwm;
    logic clear_on_match_mode;
    logic [15:0] wdata;
    logic [NUM_CH-1:0] force_ch;
    logic [NUM_CH-1:0] cmp_hit;
    logic [3:0] flag_set;
    logic [3:0] flag_clr;
    logic [31:0] next_rdata;

    assign mode = ctrl[CTL_MODE +: 4];
    assign cs = ctrl[CTL_CS +: 3];
    assign fpwm = is_fpwm(mode);
    assign clear_on_match_mode = is_ctc(mode);
    assign wdata = avs_writedata_i[15:0];
    // a write takes effect at the edge where waitrequest is seen low
    assign wr = avs_write_i && !avs_waitrequest_o;

    // bus handshake: one wait cycle, then a single-cycle answer
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            avs_waitrequest_o <= 1'b1;
        end else begin
            avs_waitrequest_o <= !((avs_read_i || avs_write_i)
                                   && avs_waitrequest_o);
        end
    end

    // read mux; unmapped offsets read zero
    always_comb begin
        next_rdata = 32'h0000_0000;
        unique case (avs_address_i)
            REG_CTRL: begin
                next_rdata[15:0] = ctrl;
                next_rdata[CTL_PIN +: NUM_CH] = wave_pin_i;
            end
            REG_COUNT: next_rdata[15:0] = count;
            REG_CMPA: next_rdata[15:0] = cmp_buf[0];
            REG_CMPB: next_rdata[15:0] = cmp_buf[1];
            REG_CAPTOP: next_rdata[15:0] = cap_top;
            REG_FLAGS: next_rdata[3:0] = flags;
            default: next_rdata = 32'h0000_0000;
        endcase
    end

    // read data captured in the wait cycle, stands at the answer edge
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            avs_readdata_o <= 32'h0000_0000;
        end else if (avs_read_i && avs_waitrequest_o) begin
            avs_readdata_o <= next_rdata;
        end
    end

    // control register
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            ctrl <= CTRL_RST;
        end else if (wr && avs_address_i == REG_CTRL) begin
            ctrl <= wdata;
        end
    end

    // prescaler counter, free running while a clock is selected
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            pre <= 10'h000;
        end else if (cs == CS_STOP) begin
            pre <= 10'h000;
        end else begin
            pre <= pre + 10'h001;
        end
    end

    // timer tick from the selected divider
    always_comb begin
        unique case (cs)
            CS_DIV1: tick = 1'b1;
            CS_DIV8: tick = (pre & PRE_T8) == PRE_T8;
            CS_DIV64: tick = (pre & PRE_T64) == PRE_T64;
            CS_DIV256: tick = (pre & PRE_T256) == PRE_T256;
            CS_DIV1024: tick = pre == PRE_T1024;
            default: tick = 1'b0;
        endcase
    end

    // top value of the running mode
    always_comb begin
        unique case (mode)
            MODE_CTC_A, MODE_FP_A: top = cmp_act[0];
            MODE_CTC_CAP, MODE_FP_CAP: top = cap_top;
            MODE_FP8: top = TOP_8;
            MODE_FP9: top = TOP_9;
            MODE_FP10: top = TOP_10;
            default: top = CNT_MAX;
        endcase
    end
    assign match_top = (count == top) && (clear_on_match_mode || fpwm);

    // counter: clear at top, else step by one per tick
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            count <= CNT_BOTTOM;
        end else if (wr && avs_address_i == REG_COUNT) begin
            count <= wdata;
        end else if (tick) begin
            if (match_top) begin
                count <= CNT_BOTTOM;
            end else begin
                count <= count + 16'h0001;
            end
        end
    end

    // capture top register, never buffered
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            cap_top <= CNT_BOTTOM;
        end else if (wr && avs_address_i == REG_CAPTOP) begin
            cap_top <= wdata;
        end
    end

    // compare buffers and active values per channel
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            for (int ch = 0; ch < NUM_CH; ch++) begin
                cmp_buf[ch] <= CNT_BOTTOM;
                cmp_act[ch] <= CNT_BOTTOM;
            end
        end else begin
            for (int ch = 0; ch < NUM_CH; ch++) begin
                if (wr && avs_address_i == (ch == 0 ? REG_CMPA : REG_CMPB))
                begin
                    cmp_buf[ch] <= wdata & fix_mask(mode);
                    if (!fpwm) begin
                        cmp_act[ch] <= wdata & fix_mask(mode);
                    end
                end else if (!fpwm) begin
                    cmp_act[ch] <= cmp_buf[ch];
                end
                if (fpwm && tick && match_top) begin
                    cmp_act[ch] <= cmp_buf[ch];
                end
            end
        end
    end

    // compare hits and force strobes
    always_comb begin
        for (int ch = 0; ch < NUM_CH; ch++) begin
            cmp_hit[ch] = tick && (count == cmp_act[ch]);
            force_ch[ch] = wr && avs_address_i == REG_FORCE
                           && avs_writedata_i[ch] && !fpwm;
        end
    end

    // flag sources and software clears
    always_comb begin
        flag_set = 4'h0;
        flag_set[FLG_OVF] = tick && ((clear_on_match_mode && count == CNT_MAX)
                                     || (fpwm && match_top));
        flag_set[FLG_CMP +: NUM_CH] = cmp_hit;
        flag_set[FLG_CAP] = tick && match_top && top_is_cap(mode);
        flag_clr = 4'h0;
        if (wr && avs_address_i == REG_FLAGS) begin
            flag_clr = avs_writedata_i[3:0];
        end
    end

    // sticky flags, write one to clear, a set wins over a clear
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            flags <= 4'h0;
        end else begin
            flags <= (flags & ~flag_clr) | flag_set;
        end
    end

    // waveform generator next state per channel
    always_comb begin
        next_wave = wave;
        for (int ch = 0; ch < NUM_CH; ch++) begin
            if (cmp_hit[ch]) begin
                unique case (ctrl[CTL_ACT + 2*ch +: 2])
                    ACT_TOGGLE: begin
                        if (!fpwm || (ch == 0 && mode == MODE_FP_A)) begin
                            next_wave[ch] = ~wave[ch];
                        end
                    end
                    ACT_CLEAR: next_wave[ch] = 1'b0;
                    ACT_SET: next_wave[ch] = 1'b1;
                    default: next_wave[ch] = wave[ch];
                endcase
            end
            // restart edge wins so compare at top gives a flat level
            if (tick && fpwm && match_top) begin
                if (ctrl[CTL_ACT + 2*ch +: 2] == ACT_CLEAR) begin
                    next_wave[ch] = 1'b1;
                end else if (ctrl[CTL_ACT + 2*ch +: 2] == ACT_SET) begin
                    next_wave[ch] = 1'b0;
                end
            end
            if (force_ch[ch]) begin
                unique case (ctrl[CTL_ACT + 2*ch +: 2])
                    ACT_TOGGLE: next_wave[ch] = ~next_wave[ch];
                    ACT_CLEAR: next_wave[ch] = 1'b0;
                    ACT_SET: next_wave[ch] = 1'b1;
                    default: next_wave[ch] = next_wave[ch];
                endcase
            end
        end
    end

    // waveform state register
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            wave <= '0;
        end else begin
            wave <= next_wave;
        end
    end

    // pin drive: waveform overrides port value, direction gates the pin
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            wave_pin_o <= '0;
            wave_pin_oe_o <= '0;
        end else begin
            for (int ch = 0; ch < NUM_CH; ch++) begin
                if (ctrl[CTL_ACT + 2*ch +: 2] != ACT_NONE) begin
                    wave_pin_o[ch] <= next_wave[ch];
                end else begin
                    wave_pin_o[ch] <= ctrl[CTL_PORT + ch];
                end
            end
            wave_pin_oe_o <= ctrl[CTL_DIR +: NUM_CH];
        end
    end

    // checks on the behaviour above
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);

    // a tick at the top value with no software count write
    sequence s_top_tick;
        tick && match_top && !(wr && avs_address_i == REG_COUNT);
    endsequence

    // a bus request seen while waitrequest is still high
    sequence s_bus_req;
        (avs_read_i || avs_write_i) && avs_waitrequest_o;
    endsequence

    // a fast pwm restart tick, count going from top to zero
    sequence s_pwm_restart;
        tick && fpwm && match_top;
    endsequence

    a_ctc_clear: assert property ((s_top_tick and clear_on_match_mode)
                                  |=> count == 16'h0000)
        else $error("count not cleared at top in clear-on-match mode");

    a_ovf_wrap: assert property (tick && clear_on_match_mode && count == CNT_MAX
                                 |=> flags[FLG_OVF])
        else $error("overflow flag missing at wrap");

    a_pwm_load: assert property ((s_top_tick and fpwm)
                                 |=> cmp_act[0] == $past(cmp_buf[0])
                                     && flags[FLG_OVF])
        else $error("buffered compare not loaded at top");

    a_cap_flag: assert property ((s_top_tick and top_is_cap(mode))
                                 |=> flags[FLG_CAP])
        else $error("capture flag missing at top");

    a_hold_idle: assert property (!tick && !wr
                                  |=> count == $past(count))
        else $error("count moved without a tick");

    a_step_one: assert property (tick && !match_top && !wr
                                 |=> count == $past(count) + 16'h0001)
        else $error("count did not step by one");

    a_fixed_top: assert property (tick && !wr
                                  && ((mode == MODE_FP8 && count == TOP_8)
                                  || (mode == MODE_FP9 && count == TOP_9)
                                  || (mode == MODE_FP10 && count == TOP_10))
                                  |=> count == 16'h0000)
        else $error("fixed top not honoured");

    a_ctc_toggle: assert property (clear_on_match_mode && cmp_hit[0] && !force_ch[0]
                                   && ctrl[9:8] == ACT_TOGGLE
                                   |=> wave[0] != $past(wave[0]))
        else $error("waveform A did not toggle on match");

    a_no_action: assert property (ctrl[9:8] == ACT_NONE
                                  ##1 ctrl[9:8] == ACT_NONE
                                  |-> $stable(wave[0]))
        else $error("waveform changed with no action set");

    a_pin_enable: assert property (wave_pin_oe_o[0]
                                   == $past(ctrl[CTL_DIR]))
        else $error("pin enable does not follow direction bit");

    a_pwm_restart: assert property ((s_pwm_restart
                                     and ctrl[9:8] == ACT_CLEAR)
                                    |=> wave[0])
        else $error("waveform A not set at the pwm restart");

    a_pwm_invert: assert property ((s_pwm_restart
                                    and ctrl[11:10] == ACT_SET)
                                   |=> !wave[1])
        else $error("waveform B not cleared at the pwm restart");

    a_mask_write: assert property (wr && avs_address_i == REG_CMPB
                                   && mode == MODE_FP8
                                   |=> cmp_buf[1][15:8] == 8'h00)
        else $error("compare B kept bits above the fixed top");

    a_force_set: assert property (force_ch[1]
                                  && ctrl[11:10] == ACT_SET |=> wave[1])
        else $error("force strobe did not set waveform B");

    a_pin_value: assert property (ctrl[9:8] != ACT_NONE
                                  |=> wave_pin_o[0] == wave[0])
        else $error("pin A does not carry the waveform");

    a_bus_answer: assert property (s_bus_req |=> !avs_waitrequest_o
                                   ##1 avs_waitrequest_o)
        else $error("bus answer not one cycle after request");

    a_reset_wave: assert property (@(posedge clk_i) disable iff (1'b0)
                                   !rst_b_i |=> wave == '0)
        else $error("waveform state not zero after reset");

endmodule : tfp_timer16

// >>> hdl/tfp_pkg.sv
// constants for the 16-bit timer: register map, fields, modes, prescale
// assumes a single 10 MHz clock and an Avalon-MM register port
package tfp_pkg;
    localparam int unsigned NUM_CH = 2;
    // register byte offsets
    localparam logic [4:0] REG_CTRL = 5'h00;
    localparam logic [4:0] REG_COUNT = 5'h04;
    localparam logic [4:0] REG_CMPA = 5'h08;
    localparam logic [4:0] REG_CMPB = 5'h0C;
    localparam logic [4:0] REG_CAPTOP = 5'h10;
    localparam logic [4:0] REG_FLAGS = 5'h14;
    localparam logic [4:0] REG_FORCE = 5'h18;
    localparam logic [15:0] CTRL_RST = 16'h0000;
    // control field positions
    localparam int unsigned CTL_MODE = 0;
    localparam int unsigned CTL_CS = 4;
    localparam int unsigned CTL_ACT = 8;
    localparam int unsigned CTL_DIR = 12;
    localparam int unsigned CTL_PORT = 14;
    localparam int unsigned CTL_PIN = 16;
    // flag bit positions
    localparam int unsigned FLG_OVF = 0;
    localparam int unsigned FLG_CMP = 1;
    localparam int unsigned FLG_CAP = 3;
    // waveform modes
    localparam logic [3:0] MODE_CTC_A = 4'h4;
    localparam logic [3:0] MODE_FP8 = 4'h5;
    localparam logic [3:0] MODE_FP9 = 4'h6;
    localparam logic [3:0] MODE_FP10 = 4'h7;
    localparam logic [3:0] MODE_CTC_CAP = 4'hC;
    localparam logic [3:0] MODE_FP_CAP = 4'hE;
    localparam logic [3:0] MODE_FP_A = 4'hF;
    localparam logic [15:0] TOP_8 = 16'h00FF;
    localparam logic [15:0] TOP_9 = 16'h01FF;
    localparam logic [15:0] TOP_10 = 16'h03FF;
    localparam logic [15:0] CNT_MAX = 16'hFFFF;
    localparam logic [15:0] CNT_BOTTOM = 16'h0000;
    // output actions
    localparam logic [1:0] ACT_NONE = 2'h0;
    localparam logic [1:0] ACT_TOGGLE = 2'h1;
    localparam logic [1:0] ACT_CLEAR = 2'h2;
    localparam logic [1:0] ACT_SET = 2'h3;
    // clock select codes and prescaler terminal masks
    localparam logic [2:0] CS_STOP = 3'h0;
    localparam logic [2:0] CS_DIV1 = 3'h1;
    localparam logic [2:0] CS_DIV8 = 3'h2;
    localparam logic [2:0] CS_DIV64 = 3'h3;
    localparam logic [2:0] CS_DIV256 = 3'h4;
    localparam logic [2:0] CS_DIV1024 = 3'h5;
    localparam logic [9:0] PRE_T8 = 10'h007;
    localparam logic [9:0] PRE_T64 = 10'h03F;
    localparam logic [9:0] PRE_T256 = 10'h0FF;
    localparam logic [9:0] PRE_T1024 = 10'h3FF;
endpackage : tfp_pkg

// >>> tb/tfp_pin_load.sv
// load on the two waveform pins: weak pull-down and the read-back path
// assumes the pin value and its enable come straight from the timer
`timescale 1ns/1ps
module tfp_pin_load
    import tfp_pkg::*;
(
    input wire logic [NUM_CH-1:0] drive_i,
    input wire logic [NUM_CH-1:0] enable_i,
    output logic [NUM_CH-1:0] level_o
);
    // a pin that nobody drives falls to the pull-down level
    assign level_o = drive_i & enable_i;
endmodule : tfp_pin_load

// >>> tb/test_timer16_clear_on_match_fast_pwm.sv
// bench for the 16-bit timer: drives the register bus, checks by read-back
// assumes one wait cycle per access and a pull-down on both pins
`timescale 1ns/1ps
module test_timer16_clear_on_match_fast_pwm
    import tfp_pkg::*;
;
    typedef struct {
        logic [31:0] exp;
        logic [31:0] mask;
        string what;
    } tfp_note_s;
    localparam int LIMIT = 30000;
    logic clk_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic [4:0] avs_address_i = 5'h00;
    logic avs_read_i = 1'b0;
    logic avs_write_i = 1'b0;
    logic [31:0] avs_writedata_i = 32'h0000_0000;
    logic [31:0] avs_readdata_o;
    logic avs_waitrequest_o;
    logic [NUM_CH-1:0] wave_pin_i;
    logic [NUM_CH-1:0] wave_pin_o;
    logic [NUM_CH-1:0] wave_pin_oe_o;
    tfp_note_s notes[$];
    tfp_note_s note;
    int fail_count = 0;
    int n_tests = 0;
    int cycles = 0;
    int fac[6] = '{0, 1, 8, 64, 256, 1024};

    // 10 MHz clock
    always #50 clk_i = ~clk_i;

    tfp_timer16 u_dut (
        .clk_i(clk_i),
        .rst_b_i(rst_b_i),
        .avs_address_i(avs_address_i),
        .avs_read_i(avs_read_i),
        .avs_write_i(avs_write_i),
        .avs_writedata_i(avs_writedata_i),
        .avs_readdata_o(avs_readdata_o),
        .avs_waitrequest_o(avs_waitrequest_o),
        .wave_pin_i(wave_pin_i),
        .wave_pin_o(wave_pin_o),
        .wave_pin_oe_o(wave_pin_oe_o)
    );

    tfp_pin_load u_load (
        .drive_i(wave_pin_o),
        .enable_i(wave_pin_oe_o),
        .level_o(wave_pin_i)
    );

    // compare each answered read against the oldest note
    always @(posedge clk_i) begin
        if (avs_read_i && avs_waitrequest_o === 1'b0) begin
            n_tests++;
            if (notes.size() == 0) begin
                fail_count++;
                $display("unexpected read: expected none seen %h",
                    avs_readdata_o);
            end else begin
                note = notes.pop_front();
                if ((avs_readdata_o & note.mask) !== note.exp) begin
                    fail_count++;
                    $display("unexpected %s: expected %h seen %h", note.what,
                        note.exp, avs_readdata_o & note.mask);
                end
            end
        end
    end

    // cut a hang short
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == LIMIT) begin
            fail_count++;
            $display("unexpected cycles: expected below %0d seen %0d",
                LIMIT, cycles);
            summarize();
        end
    end

    // one access; request held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [4:0] addr,
        input logic [31:0] data);
        int n;
        @(posedge clk_i);
        avs_address_i <= addr;
        avs_writedata_i <= data;
        avs_read_i <= ~wr;
        avs_write_i <= wr;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (avs_waitrequest_o !== 1'b0 && n < 50);
        if (n >= 50) begin
            fail_count++;
            $display("unexpected waitrequest: expected 0 seen 1");
        end
        avs_read_i <= 1'b0;
        avs_write_i <= 1'b0;
    endtask : bus

    task automatic wr(input logic [4:0] addr, input logic [31:0] data);
        bus(1'b1, addr, data);
    endtask : wr

    // note the expected value, then read
    task automatic chk(input logic [4:0] addr, input logic [31:0] exp,
        input logic [31:0] mask, input string what);
        notes.push_back('{exp & mask, mask, what});
        bus(1'b0, addr, 32'h0000_0000);
    endtask : chk

    task automatic pins(input logic [1:0] p);
        chk(REG_CTRL, 32'(p) << CTL_PIN, 32'h3 << CTL_PIN, "pins");
    endtask : pins

    function automatic logic [31:0] ctl(input logic [3:0] mode,
        input logic [2:0] cs, input logic [1:0] act_a,
        input logic [1:0] act_b, input logic [1:0] dir,
        input logic [1:0] port);
        return 32'(mode) | (32'(cs) << CTL_CS) | (32'(act_a) << CTL_ACT)
            | (32'(act_b) << (CTL_ACT + 2)) | (32'(dir) << CTL_DIR)
            | (32'(port) << CTL_PORT);
    endfunction : ctl

    // start the timer, let it tick for a window of cycles, stop it
    task automatic run(input logic [31:0] word, input int win);
        wr(REG_CTRL, word);
        repeat (win - 3) @(posedge clk_i);
        wr(REG_CTRL, word & ~(32'h7 << CTL_CS));
    endtask : run

    task automatic summarize();
        $display("comparisons %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : summarize

    initial begin
        logic [31:0] r;
        int c;
        void'($urandom(32'h08AD));
        repeat (4) @(posedge clk_i);
        rst_b_i <= 1'b1;
        chk(REG_CTRL, 32'h0, 32'hFFFF_FFFF, "ctrl");
        chk(REG_FLAGS, 32'h0, 32'hF, "flags");
        r = $urandom();
        wr(5'h1C, r);
        chk(5'h1C, 32'h0, 32'hFFFF_FFFF, "unmapped");
        wr(REG_COUNT, r);
        chk(REG_COUNT, r, 32'hFFFF, "count");
        $display("test reset done");
        // far top keeps every window inside one period
        wr(REG_CMPA, 32'hFFFF);
        for (int i = 0; i < 6; i++) begin
            wr(REG_COUNT, 32'h0);
            run(ctl(MODE_CTC_A, 3'(i), ACT_NONE, ACT_NONE, 2'h0, 2'h0),
                (i == 0) ? 10 : fac[i] * 3 + fac[i] / 2);
            r = (i == 0) ? 32'h0 : 32'h3;
            chk(REG_COUNT, r, 32'hFFFF, "count");
        end
        $display("test prescale done");
        for (int k = 0; k < 2; k++) begin
            c = (k == 0) ? 2 : 0;
            wr(REG_COUNT, 32'h0);
            wr(REG_CMPA, 32'(c));
            wr(REG_FLAGS, 32'hF);
            run(ctl(MODE_CTC_A, CS_DIV1, ACT_TOGGLE, ACT_NONE, 2'h1, 2'h0),
                (k == 0) ? 9 : 5);
            chk(REG_COUNT, 32'h0, 32'hFFFF, "count");
            chk(REG_FLAGS, 32'h2, 32'h3, "flags");
            pins((k == 0) ? 2'h1 : 2'h0);
        end
        $display("test toggle done");
        wr(REG_CTRL,
            ctl(MODE_CTC_A, CS_STOP, ACT_TOGGLE, ACT_SET, 2'h3, 2'h0));
        wr(REG_FORCE, 32'h3);
        pins(2'h3);
        $display("test force done");
        for (int k = 0; k < 2; k++) begin
            c = (k == 0) ? MODE_CTC_CAP : MODE_FP_CAP;
            wr(REG_CTRL, ctl(4'(c), CS_STOP, ACT_NONE, ACT_NONE, 2'h0, 2'h0));
            wr(REG_CAPTOP, 32'h5);
            wr(REG_COUNT, 32'hFFF0);
            wr(REG_FLAGS, 32'hF);
            run(ctl(4'(c), CS_DIV1, ACT_NONE, ACT_NONE, 2'h0, 2'h0), 24);
            chk(REG_COUNT, 32'h2, 32'hFFFF, "count");
            chk(REG_FLAGS, 32'h9, 32'h9, "flags");
        end
        $display("test wrap done");
        wr(REG_CTRL, 32'h0);
        wr(REG_CMPA, 32'h2);
        wr(REG_CTRL, ctl(MODE_FP8, CS_STOP, ACT_CLEAR, ACT_SET, 2'h3, 2'h0));
        wr(REG_CMPB, 32'h1F3);
        chk(REG_CMPB, 32'hF3, 32'hFFFF, "compare b");
        // pass one top so the buffered compare b becomes active
        wr(REG_COUNT, 32'hFF);
        run(ctl(MODE_FP8, CS_DIV1, ACT_CLEAR, ACT_SET, 2'h3, 2'h0), 3);
        wr(REG_COUNT, 32'hF0);
        wr(REG_FLAGS, 32'hF);
        run(ctl(MODE_FP8, CS_DIV1, ACT_CLEAR, ACT_SET, 2'h3, 2'h0), 17);
        chk(REG_COUNT, 32'h1, 32'hFFFF, "count");
        chk(REG_FLAGS, 32'h5, 32'hF, "flags");
        pins(2'h1);
        wr(REG_CTRL, ctl(MODE_FP8, CS_STOP, ACT_CLEAR, ACT_SET, 2'h2, 2'h0));
        pins(2'h0);
        // wider fixed tops: write mask and restart after top
        for (int k = 0; k < 2; k++) begin
            r = (k == 0) ? 32'h1FF : 32'h3FF;
            c = (k == 0) ? MODE_FP9 : MODE_FP10;
            wr(REG_CTRL, 32'(c));
            wr(REG_CMPB, 32'hFFFF);
            chk(REG_CMPB, r, 32'hFFFF, "compare b");
            wr(REG_COUNT, r - 32'h1);
            run(ctl(4'(c), CS_DIV1, ACT_NONE, ACT_NONE, 2'h0, 2'h0), 3);
            chk(REG_COUNT, 32'h1, 32'hFFFF, "count");
        end
        $display("test fixed pwm done");
        wr(REG_CTRL, 32'h0);
        wr(REG_CMPA, 32'h3);
        wr(REG_CTRL,
            ctl(MODE_FP_A, CS_STOP, ACT_TOGGLE, ACT_NONE, 2'h3, 2'h2));
        wr(REG_COUNT, 32'h0);
        wr(REG_CMPA, 32'h5);
        chk(REG_CMPA, 32'h5, 32'hFFFF, "compare a");
        wr(REG_FLAGS, 32'hF);
        run(ctl(MODE_FP_A, CS_DIV1, ACT_TOGGLE, ACT_NONE, 2'h3, 2'h2), 16);
        chk(REG_COUNT, 32'h0, 32'hFFFF, "count");
        chk(REG_FLAGS, 32'h3, 32'h3, "flags");
        pins(2'h2);
        $display("test top pwm done");
        summarize();
    end
endmodule : test_timer16_clear_on_match_fast_pwm
